/* File: pbc_pkg.sv */
// Package for the port-change GPIO block: register offsets, fields, resets.
// Assumes a single core clock and a plain strobe register port.
package pbc_pkg;
  localparam int          PBC_W            = 8;
  localparam int          PBC_AW           = 4;
  localparam logic [3:0]  PBC_OFF_DATA     = 4'h0;
  localparam logic [3:0]  PBC_OFF_DIR      = 4'h1;
  localparam logic [3:0]  PBC_OFF_OPTION   = 4'h2;
  localparam logic [3:0]  PBC_OFF_INTCTL   = 4'h3;
  localparam logic [3:0]  PBC_OFF_STATUS   = 4'h4;
  localparam logic [3:0]  PBC_OFF_MASK     = 4'h5;
  localparam int          PBC_PUN_BIT      = 7;
  localparam int          PBC_FLAG_BIT     = 0;
  localparam int          PBC_IE_BIT       = 3;
  localparam int          PBC_CHG_LO       = 4;
  localparam int          PBC_CHG_HI       = 7;
  localparam logic [7:0]  PBC_DIR_RST      = 8'hFF;
  localparam logic [7:0]  PBC_LATCH_RST    = 8'h00;
  localparam logic [7:0]  PBC_OPTION_RST   = 8'hFF;
  localparam logic [7:0]  PBC_INTCTL_RST   = 8'h00;
  localparam logic [7:0]  PBC_MASK_RST     = 8'h00;
  localparam int          PBC_SYNC_STAGES  = 2;
endpackage

/* File: pbc_sync.sv */
// Two-flop synchroniser for a bus of pin inputs.
// Assumes inputs are asynchronous to the clock; first stage feeds only the second.
module pbc_sync
  import pbc_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

/* File: pbc_port.sv */
// Eight-pin bidirectional port with pull-ups and upper-nibble change interrupt.
// Assumes a core-clock register port with single-cycle strobes, read data one cycle later.
// Overview of operation
// - Eight independent pins, each input or output
// - Direction 1 floats driver, 0 drives latch
// - Data read returns pins; write sets latch
// - Writes merge modification into sampled pin levels
// - Option bit 7 low enables all pull-ups
// - Output pins never get a pull-up
// - Pull-ups disabled after reset
// - Only input pins 7..4 take part
// - Compare against snapshot from last data read or write
// - ORed mismatches set flag at bit 0
// - Port-change interrupt wakes device from sleep
// - Data access ends mismatch; software clears flag
// - Persisting mismatch keeps setting the flag
// - Change coinciding with read still sets the flag
module pbc_port
  import pbc_pkg::*;
#(
  parameter int W = PBC_W
)
(
  input  wire logic              REF_CLK,
  input  wire logic              RST_N,
  input  wire logic [PBC_AW-1:0] ADDR,
  input  wire logic [7:0]        WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [7:0]        RDATA,
  input  wire logic [W-1:0]      PIN_IN,
  output logic      [W-1:0]      PIN_OUT,
  output logic      [W-1:0]      PIN_OE,
  output logic      [W-1:0]      PULLUP_EN,
  input  wire logic              SLEEPING,
  output logic                   WAKE,
  output logic                   IRQ
);
  logic [W-1:0] pins_s;
  logic [W-1:0] latch_q;
  logic [W-1:0] dir_q;
  logic [7:0]   option_q;
  logic [7:0]   intctl_q;
  logic [7:0]   status_q;
  logic [7:0]   mask_q;
  logic [3:0]   snap_q;
  logic [3:0]   live_in;
  logic [3:0]   mism;
  logic         change;
  logic         armed_q;
  logic         data_rd;
  logic         data_wr;
  logic         ctl_wr;
  logic         stat_rd;
  logic [7:0]   rdata_d;

  pbc_sync #(.W(W)) u_sync (
    .clk      (REF_CLK),
    .rst_n    (RST_N),
    .async_in (PIN_IN),
    .sync_out (pins_s)
  );

  assign data_rd = RD && (ADDR == PBC_OFF_DATA);
  assign data_wr = WR && (ADDR == PBC_OFF_DATA);
  assign ctl_wr  = WR && (ADDR == PBC_OFF_INTCTL);
  assign stat_rd = RD && (ADDR == PBC_OFF_STATUS);

  // Output pins are excluded; their compare term is forced quiet
  assign live_in = pins_s[PBC_CHG_HI:PBC_CHG_LO] & dir_q[PBC_CHG_HI:PBC_CHG_LO];
  assign mism    = (live_in ^ (snap_q & dir_q[PBC_CHG_HI:PBC_CHG_LO]));
  assign change  = armed_q && (|mism);

  // Full byte write; the unwritten-bit merge of bit ops happens in the core
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      latch_q <= PBC_LATCH_RST;
    else if (data_wr)
      latch_q <= WDATA[W-1:0];
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      dir_q    <= PBC_DIR_RST;
      option_q <= PBC_OPTION_RST;
      mask_q   <= PBC_MASK_RST;
    end
    else if (WR)
    begin
      if (ADDR == PBC_OFF_DIR)
        dir_q <= WDATA[W-1:0];
      if (ADDR == PBC_OFF_OPTION)
        option_q <= WDATA;
      if (ADDR == PBC_OFF_MASK)
        mask_q <= WDATA;
    end
  end

  // Any data access re-arms the snapshot; a mismatch in that same cycle still sets the flag
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      snap_q <= '0;
    else if (data_rd || data_wr)
      snap_q <= pins_s[PBC_CHG_HI:PBC_CHG_LO];
  end

  // No old value exists before the first data access; avoids a false change after reset
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      armed_q <= 1'h0;
    else if (data_rd || data_wr)
      armed_q <= 1'h1;
  end

  // Set beats clear so a live mismatch keeps the flag up
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      intctl_q <= PBC_INTCTL_RST;
    else
    begin
      if (ctl_wr)
        intctl_q <= WDATA;
      if (change)
        intctl_q[PBC_FLAG_BIT] <= 1'b1;
    end
  end

  // Sticky event status, cleared by read, set wins
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      status_q <= '0;
    else
    begin
      if (stat_rd)
        status_q <= '0;
      if (change)
        status_q[PBC_FLAG_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      PIN_OUT   <= '0;
      PIN_OE    <= '0;
      PULLUP_EN <= '0;
      IRQ       <= 1'b0;
      WAKE      <= 1'b0;
    end
    else
    begin
      PIN_OUT   <= latch_q;
      PIN_OE    <= ~dir_q;
      PULLUP_EN <= {W{~option_q[PBC_PUN_BIT]}} & dir_q;
      IRQ       <= |(status_q & mask_q);
      WAKE      <= SLEEPING && intctl_q[PBC_IE_BIT] && intctl_q[PBC_FLAG_BIT];
    end
  end

  always_comb
  begin
    rdata_d = 8'h00;
    unique case (ADDR)
      PBC_OFF_DATA:   rdata_d = pins_s;
      PBC_OFF_DIR:    rdata_d = dir_q;
      PBC_OFF_OPTION: rdata_d = option_q;
      PBC_OFF_INTCTL: rdata_d = intctl_q;
      PBC_OFF_STATUS: rdata_d = status_q;
      PBC_OFF_MASK:   rdata_d = mask_q;
      default:        rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      RDATA <= 8'h00;
    else if (RD)
      RDATA <= rdata_d;
    else
      RDATA <= 8'h00;
  end
endmodule

/* File: pbc_port_checker.sv */
// Assertions on pbc_port pins and strobes.
// Bound to pbc_port; one clock, sync reset.
module pbc_port_checker
  import pbc_pkg::*;
(
  input logic       REF_CLK,
  input logic       RST_N,
  input logic [3:0] ADDR,
  input logic [7:0] WDATA,
  input logic       WR,
  input logic       RD,
  input logic [7:0] RDATA,
  input logic [7:0] PIN_OUT,
  input logic [7:0] PIN_OE,
  input logic [7:0] PULLUP_EN
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence wr_s(logic [3:0] a);
    WR && ADDR == a;
  endsequence
  dir_oe_a: assert property (wr_s(PBC_OFF_DIR) |-> ##2 PIN_OE == ~$past(WDATA, 2))
    else $error("oe");
  latch_out_a: assert property (wr_s(PBC_OFF_DATA) |-> ##2 PIN_OUT == $past(WDATA, 2))
    else $error("out");
  pull_opt_a: assert property (wr_s(PBC_OFF_OPTION) ##1 !WR |-> ##1
    PULLUP_EN == (~PIN_OE & {8{~$past(WDATA[PBC_PUN_BIT], 2)}})) else $error("opt");
  pull_out_a: assert property ((PULLUP_EN & PIN_OE) == 8'h00) else $error("pull");
  reset_pull_a: assert property ($rose(RST_N) |-> PULLUP_EN == 8'h00)
    else $error("rst");
  rd_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("rd");
  unmapped_rd_a: assert property (RD && ADDR > PBC_OFF_MASK |=> RDATA == 8'h00)
    else $error("map");
  out_hold_a: assert property (!$past(WR, 2) |-> $stable(PIN_OUT)) else $error("hold");
endmodule
bind pbc_port pbc_port_checker i_pbc_port_checker (.REF_CLK, .RST_N, .ADDR, .WDATA, .WR, .RD,
  .RDATA, .PIN_OUT, .PIN_OE, .PULLUP_EN);

/* File: pbc_keypad.sv */
// Key pad on the pins: a pressed key pulls low.
// Lines neither driven nor pulled toggle, so a float never reads steady.
module pbc_keypad
(
  input  logic       clk,
  input  logic [7:0] key,
  input  logic [7:0] oe,
  input  logic [7:0] po,
  input  logic [7:0] pu,
  output logic [7:0] pin
);
  logic [7:0] fl_q = 8'h55;
  always_ff @(posedge clk)
    fl_q <= ~fl_q;
  assign pin = (oe & po) | (~oe & ~key & (pu | fl_q));
endmodule

/* File: pbc_port_tb_top.sv */
// Bench for pbc_port: strobe accesses, key presses.
// Assumes pbc_keypad on the pins.
module pbc_port_tb_top
  import pbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       REF_CLK = 1'h0, RST_N = 1'h0, WR = 1'h0, RD = 1'h0, SLEEPING = 1'h0, WAKE, IRQ;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00, key = 8'h00, PIN_IN, RDATA, PIN_OUT, PIN_OE, PULLUP_EN;
  int         fail_count = 0, comparisons = 0;
  always #5 REF_CLK = ~REF_CLK;
  pbc_port i_pbc_port (
    .REF_CLK   (REF_CLK),
    .RST_N     (RST_N),
    .ADDR      (ADDR),
    .WDATA     (WDATA),
    .WR        (WR),
    .RD        (RD),
    .RDATA     (RDATA),
    .PIN_IN    (PIN_IN),
    .PIN_OUT   (PIN_OUT),
    .PIN_OE    (PIN_OE),
    .PULLUP_EN (PULLUP_EN),
    .SLEEPING  (SLEEPING),
    .WAKE      (WAKE),
    .IRQ       (IRQ)
  );
  pbc_keypad i_pbc_keypad (.clk(REF_CLK), .key, .oe(PIN_OE), .po(PIN_OUT), .pu(PULLUP_EN),
    .pin(PIN_IN));
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One gap cycle between accesses keeps each strobe a single pulse
  task automatic reg_wr(logic [3:0] a, logic [7:0] d);
    @(posedge REF_CLK);
    {WR, ADDR, WDATA} <= {1'h1, a, d};
    @(posedge REF_CLK);
    WR <= 1'h0;
  endtask
  // Read data stand only in the cycle after the strobe edge
  task automatic reg_rd(logic [3:0] a, logic [7:0] exp);
    @(posedge REF_CLK);
    {RD, ADDR} <= {1'h1, a};
    @(posedge REF_CLK);
    RD <= 1'h0;
    #1 chk(RDATA, exp);
  endtask
  task automatic summarize();
    $display("%0d checks, %0d fails", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #20000;
    fail_count++;
    summarize();
  end
  initial
  begin
    repeat (12) @(posedge REF_CLK);
    RST_N <= 1'h1;
    reg_rd(4'hF, 8'h00);
    reg_rd(PBC_OFF_DIR, PBC_DIR_RST);
    chk(PULLUP_EN, 8'h00);
    reg_wr(PBC_OFF_OPTION, 8'h7F);
    reg_wr(PBC_OFF_DIR, 8'hF0);
    reg_wr(PBC_OFF_DATA, 8'hA5);
    repeat (2) @(posedge REF_CLK);
    #1 chk(PULLUP_EN, 8'hF0);
    chk(PIN_OE, 8'h0F);
    chk(PIN_OUT, 8'hA5);
    reg_rd(PBC_OFF_DATA, 8'hF5);
    reg_rd(PBC_OFF_STATUS, 8'h00);
    $display("test pins done");
    reg_wr(PBC_OFF_MASK, 8'h01);
    reg_wr(PBC_OFF_INTCTL, 8'h08);
    #1 chk({6'h00, WAKE, IRQ}, 8'h00);
    @(posedge REF_CLK);
    SLEEPING <= 1'h1;
    key      <= 8'h20;
    repeat (6) @(posedge REF_CLK);
    #1 chk({6'h00, WAKE, IRQ}, 8'h03);
    reg_wr(PBC_OFF_INTCTL, 8'h08);
    reg_rd(PBC_OFF_INTCTL, 8'h09);
    reg_rd(PBC_OFF_DATA, 8'hD5);
    reg_wr(PBC_OFF_INTCTL, 8'h08);
    reg_rd(PBC_OFF_INTCTL, 8'h08);
    reg_rd(PBC_OFF_STATUS, 8'h01);
    reg_rd(PBC_OFF_STATUS, 8'h00);
    chk({6'h00, WAKE, IRQ}, 8'h00);
    $display("test change done");
    reg_wr(PBC_OFF_DIR, 8'h70);
    reg_wr(PBC_OFF_DATA, 8'h25);
    repeat (4) @(posedge REF_CLK);
    reg_rd(PBC_OFF_INTCTL, 8'h08);
    reg_rd(PBC_OFF_DATA, 8'h55);
    $display("test output exclusion done");
    @(posedge REF_CLK);
    key   <= 8'h00;
    RST_N <= 1'h0;
    repeat (3) @(posedge REF_CLK);
    RST_N <= 1'h1;
    reg_rd(PBC_OFF_OPTION, PBC_OPTION_RST);
    chk(PULLUP_EN, 8'h00);
    chk(PIN_OE, 8'h00);
    reg_rd(PBC_OFF_DIR, PBC_DIR_RST);
    $display("test reset done");
    summarize();
  end
endmodule
